// *** bench/quad_wiper_updown_twowire_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module quad_wiper_updown_twowire_ctrl_tb_top;
    // Device type code; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE = 4'hC;
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] SA = {DEV_TYPE, STRAP, 1'b0};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic prot = 1'b0;
    logic scl, sda_m, cs_n, up_dn, sda_out, sda_oe_n;
    logic [1:0] sel;
    logic [7:0] wp [4];
    logic [255:0] ts [4];
    wire logic sda = sda_m & (sda_oe_n | sda_out);
    int fails = 0;
    int checks_done = 0;
    always #10 clk_sys = ~clk_sys;
    qw_ctrl #(.DEVICE_TYPE(DEV_TYPE)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cs_n_in(cs_n),
        .up_dn_in(up_dn), .pot_select_lo(sel[0]), .pot_select_hi(sel[1]),
        .store_protect_in(prot), .strap_addr_2(STRAP[2]),
        .strap_addr_1(STRAP[1]), .strap_addr_0(STRAP[0]),
        .wiper_pos_0(wp[0]), .wiper_pos_1(wp[1]), .wiper_pos_2(wp[2]),
        .wiper_pos_3(wp[3]), .tap_sel_0(ts[0]), .tap_sel_1(ts[1]),
        .tap_sel_2(ts[2]), .tap_sel_3(ts[3])
    );
    qw_host hst_u (
        .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_m(sda_m),
        .cs_n(cs_n), .up_dn(up_dn), .sel(sel)
    );
    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] r,
        input logic [7:0] d, input logic ok);
        logic [7:0] q;
        logic [2:0] k;
        hst_u.start();
        hst_u.byte_io(a, 1'b1, q, k[2]);
        hst_u.byte_io(r, 1'b1, q, k[1]);
        hst_u.byte_io(d, 1'b1, q, k[0]);
        hst_u.stop();
        chk("ack", {5'h0, k}, ok ? 8'h00 : 8'h07);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        hst_u.start();
        hst_u.byte_io(SA, 1'b1, q, k);
        hst_u.byte_io(r, 1'b1, q, k);
        hst_u.stop();
        hst_u.start();
        hst_u.byte_io(SA | 8'h01, 1'b1, q, k);
        hst_u.byte_io(8'hFF, 1'b0, q, k);
        chk("read", q, e);
        hst_u.byte_io(8'hFF, 1'b1, q, k);
        chk("reread", q, e);
        hst_u.stop();
    endtask
    task automatic results();
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (16) @(posedge clk_sys);
        for (int k = 0; k < 4; k++)
        begin
            chk("recall", wp[k], 8'h80);
            chk("tap", {7'h0, ts[k][8'h80]}, 8'h01);
        end
        rd(8'h07, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            hst_u.ud(2'(k), 1'b1, k + 1, 1'b0, 1'b0);
            for (int j = 0; j < 4; j++)
                chk("step", wp[j], 8'h80 + 8'(j <= k ? j + 1 : 0));
        end
        prot <= 1'b1;
        hst_u.ud(2'h2, 1'b0, 2, 1'b1, 1'b0);
        chk("down", wp[2], 8'h81);
        prot <= 1'b0;
        hst_u.ud(2'h3, 1'b1, 1, 1'b1, 1'b0);
        hst_u.ud(2'h1, 1'b1, 0, 1'b0, 1'b1);
        chk("cs step", wp[1], 8'h83);
        wr(SA, 8'h02, 8'h3C, 1'b1);
        chk("write", wp[2], 8'h3C);
        wr(SA, 8'h07, 8'h01, 1'b1);
        for (int k = 0; k < 4; k++)
            chk("saved", wp[k], k == 2 ? 8'h81 : 8'h80);
        wr(SA, 8'h03, 8'h5A, 1'b1);
        rd(8'h03, 8'h5A);
        rd(8'h07, 8'h01);
        wr(SA, 8'h07, 8'h00, 1'b1);
        rd(8'h02, 8'h81);
        wr(SA, 8'h00, 8'hFE, 1'b1);
        hst_u.ud(2'h0, 1'b1, 3, 1'b0, 1'b0);
        chk("top", wp[0], 8'hFF);
        chk("tap top", {7'h0, ts[0][255]}, 8'h01);
        wr(SA, 8'h00, 8'h01, 1'b1);
        hst_u.ud(2'h0, 1'b0, 3, 1'b0, 1'b0);
        chk("bottom", wp[0], 8'h00);
        chk("tap bottom", {7'h0, ts[0][0]}, 8'h01);
        wr(SA ^ 8'h02, 8'h00, 8'h55, 1'b0);
        wr(SA ^ 8'h80, 8'h00, 8'h55, 1'b0);
        hst_u.hold_cs(1'b0);
        wr(SA, 8'h00, 8'h55, 1'b0);
        hst_u.hold_cs(1'b1);
        chk("ignored", wp[0], 8'h00);
        results();
    end
endmodule // quad_wiper_updown_twowire_ctrl_tb_top
bind qw_ctrl qw_ctrl_props #(.TAPS(TAPS)) props_u (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .cs_n_in(cs_n_in),
    .store_protect_in(store_protect_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wiper_pos_0(wiper_pos_0),
    .wiper_pos_1(wiper_pos_1), .wiper_pos_2(wiper_pos_2),
    .wiper_pos_3(wiper_pos_3), .tap_sel_0(tap_sel_0)
);
`default_nettype wire

// *** bench/qw_ctrl_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module qw_ctrl_props #(
    parameter TAPS = 256
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic cs_n_in,
    input wire logic store_protect_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [7:0] wiper_pos_0,
    input wire logic [7:0] wiper_pos_1,
    input wire logic [7:0] wiper_pos_2,
    input wire logic [7:0] wiper_pos_3,
    input wire logic [TAPS-1:0] tap_sel_0
);
    logic [3:0] lo_q;
    logic [3:0] hi_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Counts cycles with select low, or with select and SCL both high.
    always_ff @(posedge clk_sys)
    begin
        lo_q <= (rst || cs_n_in) ? 4'h0 : lo_q + {3'h0, lo_q != 4'hF};
        hi_q <= (rst || !cs_n_in || !scl_in) ? 4'h0 :
            hi_q + {3'h0, hi_q != 4'hF};
    end
    a_tap_one_hot: assert property ($onehot(tap_sel_0))
        else $error("tap select not one-hot");
    a_tap_tracks_pos: assert property (tap_sel_0[wiper_pos_0])
        else $error("tap select differs from wiper");
    a_step_single: assert property (
        lo_q > 4'h7 && !$stable(wiper_pos_0) |-> {1'b0, wiper_pos_0}
            - {1'b0, $past(wiper_pos_0)} inside {9'h001, 9'h1FF})
        else $error("wiper moved by more than one");
    a_sda_off_sel: assert property (lo_q > 4'h7 |-> sda_oe_n)
        else $error("SDA driven while selected");
    a_sda_scl_low: assert property (
        $changed(sda_oe_n | sda_out) |-> !scl_in)
        else $error("SDA changed while SCL high");
    a_quiet_reset: assert property ($fell(rst) |-> sda_oe_n [*8])
        else $error("SDA driven after reset");
    a_recall_slot: assert property ($fell(rst) |-> ##[1:6]
        wiper_pos_0 == 8'h80 && wiper_pos_1 == 8'h80 &&
        wiper_pos_2 == 8'h80 && wiper_pos_3 == 8'h80)
        else $error("wiper not loaded from slot");
    a_hold_idle: assert property (
        hi_q > 4'h7 |-> $stable(wiper_pos_0))
        else $error("wiper moved while deselected");
    c_store: cover property ($rose(cs_n_in) && scl_in && store_protect_in);
    c_ack: cover property ($fell(sda_oe_n));
    c_top: cover property (wiper_pos_0 == 8'hFF);
endmodule // qw_ctrl_props
`default_nettype wire

// *** bench/qw_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module qw_host (
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_m = 1'b1,
    output logic cs_n = 1'b1,
    output logic up_dn = 1'b0,
    output logic [1:0] sel = 2'h0
);
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic bit_io(input logic o, output logic i);
        sda_m <= o;
        w(2);
        scl <= 1'b1;
        w(3);
        @(negedge clk_sys);
        i = sda;
        w(1);
        scl <= 1'b0;
        w(2);
    endtask
    task automatic byte_io(input logic [7:0] o, input logic ma,
        output logic [7:0] i, output logic ack);
        for (int k = 7; k >= 0; k--)
            bit_io(o[k], i[k]);
        bit_io(ma, ack);
    endtask
    task automatic start();
        sda_m <= 1'b0;
        w(8);
        scl <= 1'b0;
        w(4);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(8);
        sda_m <= 1'b1;
        w(8);
    endtask
    task automatic hold_cs(input logic v);
        cs_n <= v;
        w(8);
    endtask
    task automatic ud(input logic [1:0] p, input logic up, input int n,
        input logic st, input logic lo);
        sel <= p;
        up_dn <= up;
        scl <= !lo;
        w(8);
        cs_n <= 1'b0;
        w(8);
        repeat (n)
        begin
            scl <= 1'b1;
            w(4);
            scl <= 1'b0;
            w(4);
        end
        scl <= st;
        w(8);
        cs_n <= 1'b1;
        w(8);
        scl <= 1'b1;
        w(16);
    endtask
endmodule // qw_host
`default_nettype wire

// *** inc/qw_consts.vh ***
`ifndef QW_CONSTS_VH
`define QW_CONSTS_VH

// Register address byte of the control register.
`define QW_CTRL_ADDR 8'h07
// Highest address byte that selects a potentiometer channel.
`define QW_POT_ADDR_MAX 8'h03
// Control register reset value and field positions.
`define QW_CTRL_RST 3'h0
`define QW_CTRL_NV_EN_BIT 0
`define QW_CTRL_SLOT_LO_BIT 1
`define QW_CTRL_SLOT_HI_BIT 2
// Wiper end codes.
`define QW_WIPER_MIN 8'h00
`define QW_WIPER_MAX 8'hFF
// Saved-slot content after a full reset.
`define QW_SAVED_RST 8'h80
// Data bits per byte on the 2-wire link.
`define QW_BITS_PER_BYTE 4'h8

`endif

// *** logic/qw_ctrl.v ***
// Behaviour
// - Position decodes to exactly one of 256 taps.
// - Zero is low end, all ones high end.
// - Power-up copies slot zero into each wiper.
// - Up/down responds only while chip select low.
// - SCL fall steps selected wiper by direction.
// - Two select pins pick potentiometer, high MSB.
// - Chip select rise, SCL high, protect high: store.
// - Protect low on rise: skip store, standby.
// - SCL low on rise: deselect, keep wiper.
// - Chip select low disables 2-wire interface.
// - Chip select fall with SCL low also steps.
// - Device is slave; START and address first.
// - Bytes travel most significant bit first.
// - SDA fall with SCL high is START.
// - SDA rise with SCL high is STOP.
// - Receiver drives SDA low in ninth clock.
// - Acknowledge only matching type and strap address.
// - Address bit zero selects read or write.
// - Acknowledge every written byte after address.
// - Read continues only while master acknowledges.
// - SDA released after reset until addressed.
// - Control register at 07h, resets to zero.
`timescale 1ns/10ps
`default_nettype none
`include "qw_consts.vh"

module qw_ctrl #(
    parameter TAPS = 256,
    // Device type code; the value is arbitrary.
    parameter [3:0] DEVICE_TYPE = 4'hA
) (
    input wire clk_sys,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire cs_n_in,
    input wire up_dn_in,
    input wire pot_select_lo,
    input wire pot_select_hi,
    input wire store_protect_in,
    input wire strap_addr_2,
    input wire strap_addr_1,
    input wire strap_addr_0,
    output reg [7:0] wiper_pos_0,
    output reg [7:0] wiper_pos_1,
    output reg [7:0] wiper_pos_2,
    output reg [7:0] wiper_pos_3,
    output wire [TAPS-1:0] tap_sel_0,
    output wire [TAPS-1:0] tap_sel_1,
    output wire [TAPS-1:0] tap_sel_2,
    output wire [TAPS-1:0] tap_sel_3
);
    localparam ST_IDLE = 3'd0;
    localparam ST_RX = 3'd1;
    localparam ST_ACK = 3'd2;
    localparam ST_TX = 3'd3;
    localparam ST_MACK = 3'd4;
    localparam ST_RECALL = 3'd5;

    // Two-stage synchronisers; stage one is read only by stage two.
    reg [9:0] in_s1_q;
    reg [9:0] in_s2_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg cs_n_prev_q;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            in_s1_q <= 10'h3FF;
            in_s2_q <= 10'h3FF;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            cs_n_prev_q <= 1'b1;
        end
        else
        begin
            in_s1_q <= {strap_addr_2, strap_addr_1, strap_addr_0,
                store_protect_in, pot_select_hi, pot_select_lo,
                up_dn_in, cs_n_in, sda_in, scl_in};
            in_s2_q <= in_s1_q;
            scl_prev_q <= in_s2_q[0];
            sda_prev_q <= in_s2_q[1];
            cs_n_prev_q <= in_s2_q[2];
        end
    end

    wire scl = in_s2_q[0];
    wire sda = in_s2_q[1];
    wire cs_n = in_s2_q[2];
    wire up_dn = in_s2_q[3];
    wire [1:0] pot_sel = in_s2_q[5:4];
    wire protect = in_s2_q[6];
    wire [2:0] strap = in_s2_q[9:7];

    wire scl_rise = scl & ~scl_prev_q;
    wire scl_fall = ~scl & scl_prev_q;
    wire cs_fall = ~cs_n & cs_n_prev_q;
    wire cs_rise = cs_n & ~cs_n_prev_q;
    wire start_cond = scl & scl_prev_q & ~sda & sda_prev_q;
    wire stop_cond = scl & scl_prev_q & sda & ~sda_prev_q;

    // Wiper positions and saved slots, indexed pot*4+slot.
    reg [7:0] wiper_q [0:3];
    reg [7:0] saved_q [0:15];
    reg [2:0] ctrl_q;
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg [7:0] reg_addr_q;
    reg [1:0] byte_idx_q;
    reg rd_q;
    reg mack_q;
    integer i;

    // Up/down step request: SCL fall while selected, or select fall with SCL low.
    wire step = (~cs_n & scl_fall) | (cs_fall & ~scl);
    wire [7:0] cur = wiper_q[pot_sel];
    wire [7:0] stepped = up_dn ?
        ((cur == `QW_WIPER_MAX) ? cur : cur + 8'h01) :
        ((cur == `QW_WIPER_MIN) ? cur : cur - 8'h01);

    wire [1:0] slot = {ctrl_q[`QW_CTRL_SLOT_HI_BIT],
        ctrl_q[`QW_CTRL_SLOT_LO_BIT]};
    wire nv_en = ctrl_q[`QW_CTRL_NV_EN_BIT];
    wire [1:0] pot_addr = reg_addr_q[1:0];
    wire pot_hit = (reg_addr_q <= `QW_POT_ADDR_MAX);
    wire ctrl_hit = (reg_addr_q == `QW_CTRL_ADDR);
    wire [7:0] rx_byte = {shift_q[6:0], sda};
    wire addr_match = (shift_q[7:4] == DEVICE_TYPE) &&
        (shift_q[3:1] == strap);

    // Read data for the current register address.
    reg [7:0] rd_data;
    always @*
    begin
        rd_data = 8'h00;
        if (ctrl_hit)
            rd_data = {5'h00, ctrl_q};
        else if (pot_hit && nv_en)
            rd_data = saved_q[{pot_addr, slot}];
        else if (pot_hit)
            rd_data = wiper_q[pot_addr];
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (i = 0; i < 16; i = i + 1)
                saved_q[i] <= `QW_SAVED_RST;
            for (i = 0; i < 4; i = i + 1)
                wiper_q[i] <= `QW_WIPER_MIN;
            ctrl_q <= `QW_CTRL_RST;
            state_q <= ST_RECALL;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            reg_addr_q <= 8'h00;
            byte_idx_q <= 2'd0;
            rd_q <= 1'b0;
            mack_q <= 1'b0;
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
        end
        else if (state_q == ST_RECALL)
        begin
            for (i = 0; i < 4; i = i + 1)
                wiper_q[i] <= saved_q[i*4];
            state_q <= ST_IDLE;
        end
        else
        begin
            // Up/down interface.
            if (step)
                wiper_q[pot_sel] <= stepped;
            if (cs_rise && scl && protect)
                saved_q[{pot_sel, 2'b00}] <= cur;
            // A rise with SCL low or protect low only deselects.

            // 2-wire slave, held idle while chip select is low.
            if (~cs_n)
            begin
                state_q <= ST_IDLE;
                sda_oe_n <= 1'b1;
                sda_out <= 1'b1;
            end
            else if (start_cond)
            begin
                state_q <= ST_RX;
                bit_cnt_q <= 4'h0;
                byte_idx_q <= 2'd0;
                sda_oe_n <= 1'b1;
                sda_out <= 1'b1;
            end
            else if (stop_cond)
            begin
                state_q <= ST_IDLE;
                sda_oe_n <= 1'b1;
                sda_out <= 1'b1;
            end
            else
            begin
                case (state_q)
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= rx_byte;
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == `QW_BITS_PER_BYTE)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (byte_idx_q == 2'd0)
                            begin
                                if (addr_match)
                                begin
                                    rd_q <= shift_q[0];
                                    state_q <= ST_ACK;
                                    sda_oe_n <= 1'b0;
                                    sda_out <= 1'b0;
                                end
                                else
                                    state_q <= ST_IDLE;
                            end
                            else
                            begin
                                state_q <= ST_ACK;
                                sda_oe_n <= 1'b0;
                                sda_out <= 1'b0;
                                if (byte_idx_q == 2'd1)
                                    reg_addr_q <= shift_q;
                                else if (ctrl_hit)
                                begin
                                    ctrl_q <= shift_q[2:0];
                                    if (shift_q[`QW_CTRL_NV_EN_BIT])
                                        for (i = 0; i < 4; i = i + 1)
                                            wiper_q[i] <= saved_q[i*4 +
                                                shift_q[2:1]];
                                end
                                else if (pot_hit)
                                begin
                                    wiper_q[pot_addr] <= shift_q;
                                    if (nv_en)
                                        saved_q[{pot_addr, slot}] <= shift_q;
                                end
                            end
                            if (byte_idx_q != 2'd2)
                                byte_idx_q <= byte_idx_q + 2'd1;
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rd_q)
                            begin
                                state_q <= ST_TX;
                                sda_out <= rd_data[7];
                                tx_q <= {rd_data[6:0], 1'b0};
                            end
                            else
                            begin
                                state_q <= ST_RX;
                                sda_oe_n <= 1'b1;
                                sda_out <= 1'b1;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_rise)
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        else if (scl_fall)
                        begin
                            if (bit_cnt_q == `QW_BITS_PER_BYTE)
                            begin
                                state_q <= ST_MACK;
                                bit_cnt_q <= 4'h0;
                                sda_oe_n <= 1'b1;
                                sda_out <= 1'b1;
                            end
                            else
                            begin
                                sda_out <= tx_q[7];
                                tx_q <= {tx_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                            mack_q <= ~sda;
                        else if (scl_fall)
                        begin
                            if (mack_q)
                            begin
                                state_q <= ST_TX;
                                sda_oe_n <= 1'b0;
                                sda_out <= rd_data[7];
                                tx_q <= {rd_data[6:0], 1'b0};
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                        sda_oe_n <= 1'b1;
                        sda_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            wiper_pos_0 <= `QW_WIPER_MIN;
            wiper_pos_1 <= `QW_WIPER_MIN;
            wiper_pos_2 <= `QW_WIPER_MIN;
            wiper_pos_3 <= `QW_WIPER_MIN;
        end
        else
        begin
            wiper_pos_0 <= wiper_q[0];
            wiper_pos_1 <= wiper_q[1];
            wiper_pos_2 <= wiper_q[2];
            wiper_pos_3 <= wiper_q[3];
        end
    end

    qw_tap_decode #(.TAPS(TAPS)) u_tap0 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wiper_position(wiper_q[0]),
        .tap_sel(tap_sel_0)
    );
    qw_tap_decode #(.TAPS(TAPS)) u_tap1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wiper_position(wiper_q[1]),
        .tap_sel(tap_sel_1)
    );
    qw_tap_decode #(.TAPS(TAPS)) u_tap2 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wiper_position(wiper_q[2]),
        .tap_sel(tap_sel_2)
    );
    qw_tap_decode #(.TAPS(TAPS)) u_tap3 (
        .clk_sys(clk_sys),
        .rst(rst),
        .wiper_position(wiper_q[3]),
        .tap_sel(tap_sel_3)
    );
endmodule // qw_ctrl

`default_nettype wire

// *** logic/qw_tap_decode.v ***
`timescale 1ns/10ps
`default_nettype none

// Registered one-hot decode of a wiper position onto its tap switches.
module qw_tap_decode #(
    parameter TAPS = 256
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] wiper_position,
    output reg [TAPS-1:0] tap_sel
);
    always @(posedge clk_sys)
    begin
        if (rst)
            tap_sel <= {{(TAPS-1){1'b0}}, 1'b1};
        else
            tap_sel <= {{(TAPS-1){1'b0}}, 1'b1} << wiper_position;
    end
endmodule // qw_tap_decode

`default_nettype wire
